//--- hw/rplt_pkg.sv
// Constants for register preload, observability and power-up reset logic
package rplt_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCELL = 24;
    localparam int NGRP = 12;
    localparam int AW = 8;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] LOAD_DATA_ADDR = 8'h04;
    localparam logic [7:0] STROBE_ADDR = 8'h08;
    localparam logic [7:0] FUSE_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    localparam logic [7:0] FIRST_RD_ADDR = 8'h14;
    localparam logic [7:0] BURIED_RD_ADDR = 8'h18;
    localparam logic [7:0] POLARITY_ADDR = 8'h1C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_PRELOAD_BIT = 0;
    localparam int CTRL_OBSERVE_BIT = 1;
    localparam int CTRL_PAIR_SEL_BIT = 2;
    localparam int CTRL_PARITY_SEL_BIT = 3;
    localparam int STROBE_BIT = 0;
    localparam int FUSE_BIT = 0;
    localparam int ST_FUSE_BIT = 0;
    localparam int ST_PRELOAD_BIT = 1;
    localparam int ST_OBSERVE_BIT = 2;
    localparam int ST_PR_BUSY_BIT = 3;

    // ****************************************
    // Reset values and responses
    // ****************************************
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [11:0] LOAD_DATA_RESET = 12'h000;
    localparam logic [23:0] POLARITY_RESET = 24'h000000;
    // Value a fused verify read returns: every location programmed
    localparam logic [23:0] PROGRAMMED_VALUE = 24'h000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PR_INTERVAL_NS = 600;
    localparam int PR_CYCLES = (PR_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRW = 7;
    localparam logic [PRW-1:0] PR_LAST = PRW'(PR_CYCLES - 1);

endpackage

//--- hw/rplt_bank_if.sv
// Control and state signals between the top and one flop bank
`timescale 1ns/100ps
interface rplt_bank_if;
    logic clear;
    logic [23:0] load_mask;
    logic [23:0] load_data;
    logic [23:0] d;
    logic [23:0] cap;
    logic [23:0] q;
    modport ctl (output clear, output load_mask, output load_data, output d, output cap, input q);
    modport bank (input clear, input load_mask, input load_data, input d, input cap, output q);
endinterface

//--- hw/rplt_flop_bank.sv
// One bank of macrocell flops with clear, force-load and normal capture
`timescale 1ns/100ps
module rplt_flop_bank #(
    parameter int W = 24
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Bank control
    rplt_bank_if.bank bus
);

    logic [W-1:0] q_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_flop
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    q_reg[i] <= 1'b0;
                end
                else if (ce)
                begin
                    if (bus.clear)
                    begin
                        q_reg[i] <= 1'b0;
                    end
                    else if (bus.load_mask[i])
                    begin
                        q_reg[i] <= bus.load_data[i];
                    end
                    else if (bus.cap[i])
                    begin
                        q_reg[i] <= bus.d[i];
                    end
                end
            end
        end
    endgenerate

    assign bus.q = q_reg;

endmodule // rplt_flop_bank

//--- hw/rplt_top.sv
// Register preload, buried-flop observability, power-up reset and security fuse
//
// Summary of operation
// - Force-load sets even or odd flops to load data register bits
// - Load strobe captures twelve flops at once
// - Pair and parity selects choose flop group
// - Observe mode shows buried flops on outputs
// - Supply crossing trip clears every flop
// - Pins show cleared value through polarity
// - Fused polarity register reads return all programmed
// - Fuse blocks preload and observe modes
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module rplt_top (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Supply monitor
    input wire logic supply_above_trip,
    // Logic array terms
    input wire logic [23:0] array_d_first,
    input wire logic [23:0] array_d_buried,
    input wire logic [23:0] array_cap_first,
    input wire logic [23:0] array_cap_buried,
    input wire logic [23:0] array_oe,
    // Output pins
    output logic [23:0] pin_out,
    output logic [23:0] pin_oe_n
);

    // ****************************************
    // Registers
    // ****************************************
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_full_reg, w_full_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic [7:0] awaddr_reg;
    logic [3:0] ctrl_reg;
    logic [11:0] load_data_reg;
    logic [23:0] polarity_reg;
    logic fuse_reg, strobe_reg;
    logic supply_q_reg, pr_busy_reg, pr_clear_reg;
    logic [rplt_pkg::PRW-1:0] pr_cnt_reg;
    logic [23:0] pin_out_reg, pin_oe_n_reg;

    logic [31:0] wmask;
    logic do_write;
    logic preload_active, observe_active;
    logic [23:0] grp_mask, grp_data;

    rplt_bank_if first_if ();
    rplt_bank_if buried_if ();

    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign preload_active = ctrl_reg[rplt_pkg::CTRL_PRELOAD_BIT] && !fuse_reg;
    assign observe_active = ctrl_reg[rplt_pkg::CTRL_OBSERVE_BIT] && !fuse_reg;

    // ****************************************
    // Write channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= rplt_pkg::RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && awready_reg)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                if (awaddr_reg == rplt_pkg::CTRL_ADDR || awaddr_reg == rplt_pkg::LOAD_DATA_ADDR
                    || awaddr_reg == rplt_pkg::STROBE_ADDR || awaddr_reg == rplt_pkg::FUSE_ADDR
                    || awaddr_reg == rplt_pkg::POLARITY_ADDR)
                begin
                    bresp_reg <= rplt_pkg::RESP_OKAY;
                end
                else
                begin
                    bresp_reg <= rplt_pkg::RESP_SLVERR;
                end
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= rplt_pkg::CTRL_RESET;
            load_data_reg <= rplt_pkg::LOAD_DATA_RESET;
            polarity_reg <= rplt_pkg::POLARITY_RESET;
            fuse_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end
        else if (ce)
        begin
            strobe_reg <= 1'b0;
            if (do_write)
            begin
                if (awaddr_reg == rplt_pkg::CTRL_ADDR)
                begin
                    ctrl_reg <= (ctrl_reg & ~wmask[3:0]) | (wdata_reg[3:0] & wmask[3:0]);
                end
                else if (awaddr_reg == rplt_pkg::LOAD_DATA_ADDR)
                begin
                    load_data_reg <= (load_data_reg & ~wmask[11:0]) | (wdata_reg[11:0] & wmask[11:0]);
                end
                else if (awaddr_reg == rplt_pkg::STROBE_ADDR)
                begin
                    strobe_reg <= wdata_reg[rplt_pkg::STROBE_BIT] && wmask[rplt_pkg::STROBE_BIT];
                end
                else if (awaddr_reg == rplt_pkg::FUSE_ADDR)
                begin
                    if (wdata_reg[rplt_pkg::FUSE_BIT] && wmask[rplt_pkg::FUSE_BIT])
                    begin
                        fuse_reg <= 1'b1;
                    end
                end
                else if (awaddr_reg == rplt_pkg::POLARITY_ADDR)
                begin
                    polarity_reg <= (polarity_reg & ~wmask[23:0]) | (wdata_reg[23:0] & wmask[23:0]);
                end
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= rplt_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && arready_reg)
            begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg <= rplt_pkg::RESP_OKAY;
                rdata_reg <= 32'h00000000;
                if (s_axi_araddr == rplt_pkg::CTRL_ADDR)
                begin
                    rdata_reg[3:0] <= ctrl_reg;
                end
                else if (s_axi_araddr == rplt_pkg::LOAD_DATA_ADDR)
                begin
                    rdata_reg[11:0] <= load_data_reg;
                end
                else if (s_axi_araddr == rplt_pkg::STROBE_ADDR)
                begin
                    rdata_reg <= 32'h00000000;
                end
                else if (s_axi_araddr == rplt_pkg::FUSE_ADDR)
                begin
                    rdata_reg[rplt_pkg::FUSE_BIT] <= fuse_reg;
                end
                else if (s_axi_araddr == rplt_pkg::STATUS_ADDR)
                begin
                    rdata_reg[rplt_pkg::ST_FUSE_BIT] <= fuse_reg;
                    rdata_reg[rplt_pkg::ST_PRELOAD_BIT] <= preload_active;
                    rdata_reg[rplt_pkg::ST_OBSERVE_BIT] <= observe_active;
                    rdata_reg[rplt_pkg::ST_PR_BUSY_BIT] <= pr_busy_reg;
                end
                else if (s_axi_araddr == rplt_pkg::FIRST_RD_ADDR)
                begin
                    rdata_reg[23:0] <= first_if.q;
                end
                else if (s_axi_araddr == rplt_pkg::BURIED_RD_ADDR)
                begin
                    rdata_reg[23:0] <= buried_if.q;
                end
                else if (s_axi_araddr == rplt_pkg::POLARITY_ADDR)
                begin
                    rdata_reg[23:0] <= fuse_reg ? rplt_pkg::PROGRAMMED_VALUE : polarity_reg;
                end
                else
                begin
                    rresp_reg <= rplt_pkg::RESP_SLVERR;
                end
            end
            else if (rvalid_reg && s_axi_rready)
            begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Power-up reset
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            supply_q_reg <= 1'b0;
            pr_busy_reg <= 1'b0;
            pr_clear_reg <= 1'b0;
            pr_cnt_reg <= '0;
        end
        else if (ce)
        begin
            supply_q_reg <= supply_above_trip;
            pr_clear_reg <= 1'b0;
            if (supply_above_trip && !supply_q_reg)
            begin
                pr_busy_reg <= 1'b1;
                pr_cnt_reg <= '0;
            end
            else if (pr_busy_reg)
            begin
                if (pr_cnt_reg == rplt_pkg::PR_LAST)
                begin
                    pr_busy_reg <= 1'b0;
                    pr_clear_reg <= 1'b1;
                end
                else
                begin
                    pr_cnt_reg <= pr_cnt_reg + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Force-load group select
    // ****************************************
    // parity picks even or odd cells
    always_comb
    begin
        grp_mask = 24'h000000;
        grp_data = 24'h000000;
        for (int k = 0; k < rplt_pkg::NGRP; k++)
        begin
            grp_mask[2 * k + int'(ctrl_reg[rplt_pkg::CTRL_PARITY_SEL_BIT])] = 1'b1;
            grp_data[2 * k + int'(ctrl_reg[rplt_pkg::CTRL_PARITY_SEL_BIT])] = load_data_reg[k];
        end
    end

    assign first_if.load_mask = (strobe_reg && preload_active && !ctrl_reg[rplt_pkg::CTRL_PAIR_SEL_BIT])
        ? grp_mask : 24'h000000;
    assign buried_if.load_mask = (strobe_reg && preload_active && ctrl_reg[rplt_pkg::CTRL_PAIR_SEL_BIT])
        ? grp_mask : 24'h000000;
    assign first_if.load_data = grp_data;
    assign buried_if.load_data = grp_data;
    assign first_if.clear = pr_clear_reg;
    assign buried_if.clear = pr_clear_reg;
    assign first_if.d = array_d_first;
    assign buried_if.d = array_d_buried;
    assign first_if.cap = array_cap_first;
    assign buried_if.cap = array_cap_buried;

    rplt_flop_bank #(.W(rplt_pkg::NCELL)) u_first (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .bus(first_if.bank)
    );

    rplt_flop_bank #(.W(rplt_pkg::NCELL)) u_buried (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .bus(buried_if.bank)
    );

    // ****************************************
    // Output pins
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_reg <= 24'h000000;
            pin_oe_n_reg <= 24'hFFFFFF;
        end
        else if (ce)
        begin
            pin_out_reg <= (observe_active ? buried_if.q : first_if.q) ^ polarity_reg;
            pin_oe_n_reg <= ~array_oe;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;

endmodule // rplt_top

//--- bench/rplt_chk.sv
// Port-level assertions for the register preload and power-up reset block
`timescale 1ns/100ps
module rplt_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Supply and pins
    input wire logic supply_above_trip,
    input wire logic [23:0] array_oe,
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe_n
);
    logic wr_take;
    logic [23:0] pol_reg;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // Mirror of the programmed output polarity
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pol_reg <= 24'h000000;
        else if (wr_take && s_axi_awaddr == rplt_pkg::POLARITY_ADDR)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (s_axi_wstrb[b])
                    pol_reg[8 * b +: 8] <= s_axi_wdata[8 * b +: 8];
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Assertions
    // ****************************************
    a_write_timing: assert property (wr_take |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after take");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channels not reopened after response");
    a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_timing: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after take");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened after data");
    a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_oe_follow: assert property ($past(aresetn) && $past(ce) |-> pin_oe_n == ~$past(array_oe))
        else $error("output enable does not follow its term");
    a_pwr_clear: assert property ($rose(supply_above_trip) |-> ##66 pin_out == pol_reg)
        else $error("pins not at cleared value after power-up");

    c_write: cover property (wr_take);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_power_up: cover property ($rose(supply_above_trip));
endmodule // rplt_chk

//--- bench/rplt_tester_model.sv
// Tester-side model of supply monitor, array terms and clock terms
`timescale 1ns/100ps
module rplt_tester_model (
    // Clock
    input wire logic aclk,
    // Bench control
    input wire logic power_on,
    input wire logic cap_go,
    input wire logic [23:0] d_pat,
    input wire logic [23:0] oe_pat,
    // Device side
    output logic supply_above_trip,
    output logic [23:0] array_d_first,
    output logic [23:0] array_d_buried,
    output logic [23:0] array_cap_first,
    output logic [23:0] array_cap_buried,
    output logic [23:0] array_oe
);
    logic sup_reg = 1'b0;
    logic [7:0] settle_reg = 8'h00;
    always @(posedge aclk)
    begin
        sup_reg <= power_on;
        if (!power_on)
            settle_reg <= 8'h00;
        else if (settle_reg != 8'hFF)
            settle_reg <= settle_reg + 8'h01;
    end
    assign supply_above_trip = sup_reg;
    assign array_cap_first = (settle_reg == 8'hFF && cap_go) ? 24'hFFFFFF : 24'h000000;
    assign array_cap_buried = array_cap_first;
    assign array_d_first = d_pat;
    assign array_d_buried = ~d_pat;
    assign array_oe = oe_pat;
endmodule // rplt_tester_model

//--- bench/register_preload_test_and_power_up_reset_test.sv
// Self-checking bench for the register preload and power-up reset block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module register_preload_test_and_power_up_reset_test;
    logic aclk = 1'b0, aresetn = 1'b0, power_on = 1'b0, cap_go = 1'b0, ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, supply;
    logic [1:0] bresp, rresp;
    logic [23:0] d_pat = 24'h0, oe_pat = 24'h0, exp_f = 24'h0, exp_b = 24'h0, pol = 24'h0;
    logic [23:0] d_first, d_buried, cap_first, cap_buried, arr_oe, pin_out, pin_oe_n;
    int n_errors = 0;
    int checks = 0;

    always #5 aclk = ~aclk;

    rplt_top u_rplt_top (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_above_trip(supply),
        .array_d_first(d_first), .array_d_buried(d_buried), .array_cap_first(cap_first),
        .array_cap_buried(cap_buried), .array_oe(arr_oe), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
    );
    rplt_tester_model u_rplt_tester_model (
        .aclk(aclk), .power_on(power_on), .cap_go(cap_go), .d_pat(d_pat), .oe_pat(oe_pat),
        .supply_above_trip(supply), .array_d_first(d_first), .array_d_buried(d_buried),
        .array_cap_first(cap_first), .array_cap_buried(cap_buried), .array_oe(arr_oe)
    );

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = rplt_pkg::RESP_OKAY);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        `CHK("bvalid", 1'b1, bvalid)
        `CHK("bresp", er, bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = rplt_pkg::RESP_OKAY);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK($sformatf("rdata %h", a), e, rdata)
        `CHK("rresp", er, rresp)
    endtask

    task automatic finish_test();
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic t_reset();
        rd(rplt_pkg::CTRL_ADDR, {28'h0, rplt_pkg::CTRL_RESET});
        rd(rplt_pkg::LOAD_DATA_ADDR, {20'h0, rplt_pkg::LOAD_DATA_RESET});
        rd(rplt_pkg::POLARITY_ADDR, {8'h0, rplt_pkg::POLARITY_RESET});
        rd(rplt_pkg::STATUS_ADDR, 32'h0);
        `CHK("pin_oe_n", 24'hFFFFFF, pin_oe_n)
    endtask

    task automatic t_power_up();
        power_on <= 1'b1;
        repeat (300) @(posedge aclk);
        d_pat <= 24'h5A3C96;
        cap_go <= 1'b1;
        @(posedge aclk);
        cap_go <= 1'b0;
        rd(rplt_pkg::FIRST_RD_ADDR, 32'h005A3C96);
        rd(rplt_pkg::BURIED_RD_ADDR, 32'h00A5C369);
        pol = 24'hF0F00F;
        wr(rplt_pkg::POLARITY_ADDR, {8'h0, pol});
        power_on <= 1'b0;
        repeat (4) @(posedge aclk);
        power_on <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(rplt_pkg::STATUS_ADDR, 32'h8);
        repeat (60) @(posedge aclk);
        rd(rplt_pkg::STATUS_ADDR, 32'h0);
        rd(rplt_pkg::FIRST_RD_ADDR, 32'h0);
        rd(rplt_pkg::BURIED_RD_ADDR, 32'h0);
        `CHK("pin_out", pol, pin_out)
    endtask

    task automatic t_preload();
        logic [11:0] ld_tbl [4] = '{12'hA5C, 12'hFFF, 12'h3C1, 12'h96A};
        logic [1:0] s;
        int c;
        int k;
        wr(rplt_pkg::LOAD_DATA_ADDR, 32'hFFF);
        wr(rplt_pkg::STROBE_ADDR, 32'h1);
        rd(rplt_pkg::FIRST_RD_ADDR, 32'h0);
        for (c = 0; c < 4; c++)
        begin
            s = 2'(c);
            wr(rplt_pkg::CTRL_ADDR, {28'h0, s, 2'h1});
            wr(rplt_pkg::LOAD_DATA_ADDR, {20'h0, ld_tbl[c]});
            wr(rplt_pkg::STROBE_ADDR, 32'h1);
            for (k = 0; k < 12; k++)
            begin
                if (s[0])
                    exp_b[2 * k + s[1]] = ld_tbl[c][k];
                else
                    exp_f[2 * k + s[1]] = ld_tbl[c][k];
            end
            rd(rplt_pkg::STATUS_ADDR, 32'h2);
            rd(rplt_pkg::FIRST_RD_ADDR, {8'h0, exp_f});
            rd(rplt_pkg::BURIED_RD_ADDR, {8'h0, exp_b});
        end
    endtask

    task automatic t_observe();
        oe_pat <= 24'h0FF0F0;
        wr(rplt_pkg::CTRL_ADDR, 32'h2);
        rd(rplt_pkg::STATUS_ADDR, 32'h4);
        `CHK("pin_out", exp_b ^ pol, pin_out)
        `CHK("pin_oe_n", 24'hF00F0F, pin_oe_n)
        wr(rplt_pkg::CTRL_ADDR, 32'h0);
        rd(rplt_pkg::STATUS_ADDR, 32'h0);
        `CHK("pin_out", exp_f ^ pol, pin_out)
        ce <= 1'b0;
        oe_pat <= 24'h000000;
        repeat (3) @(posedge aclk);
        `CHK("pin_oe_n frozen", 24'hF00F0F, pin_oe_n)
        ce <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("pin_oe_n", 24'hFFFFFF, pin_oe_n)
    endtask

    task automatic t_bus_err();
        wr(8'h20, 32'hFFFF, rplt_pkg::RESP_SLVERR);
        rd(8'h24, 32'h0, rplt_pkg::RESP_SLVERR);
        rd(rplt_pkg::STROBE_ADDR, 32'h0);
        wstrb <= 4'h1;
        wr(rplt_pkg::POLARITY_ADDR, 32'h0);
        wstrb <= 4'hF;
        pol[7:0] = 8'h00;
        rd(rplt_pkg::POLARITY_ADDR, {8'h0, pol});
    endtask

    task automatic t_fuse();
        wr(rplt_pkg::FUSE_ADDR, 32'h1);
        rd(rplt_pkg::POLARITY_ADDR, {8'h0, rplt_pkg::PROGRAMMED_VALUE});
        wr(rplt_pkg::CTRL_ADDR, 32'hB);
        wr(rplt_pkg::LOAD_DATA_ADDR, 32'hFFF);
        wr(rplt_pkg::STROBE_ADDR, 32'h1);
        rd(rplt_pkg::STATUS_ADDR, 32'h1);
        rd(rplt_pkg::FIRST_RD_ADDR, {8'h0, exp_f});
        `CHK("pin_out", exp_f ^ pol, pin_out)
    endtask

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_power_up();
        t_preload();
        t_observe();
        t_bus_err();
        t_fuse();
        finish_test();
    end

    initial
    begin
        #100000;
        n_errors++;
        finish_test();
    end
endmodule // register_preload_test_and_power_up_reset_test

bind rplt_top rplt_chk u_rplt_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .supply_above_trip(supply_above_trip), .array_oe(array_oe),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);
